// ==== sct_pkg.sv ====
// Package with the register map, field positions and timing constants
// of the split-capable timer control block.
// Assumes a 32-bit classic Wishbone register port with a byte address.
//
// Summary of operation
// - Split clock-out toggles the clock-out pin on every low-half overflow.
// - Low-half overflow in split mode reloads the low counter from its reload byte.
// - While split clock-out is active, low-half overflows set no low overflow flag.
// - A 16-bit or split high-half overflow sets the main overflow flag; only software clears it.
// - Enabled falling or rising external edge sets the external flag and requests interrupt.
// - In power-down with interrupt enabled the external condition acts as a level.
// - Split low-half overflow sets low flag; interrupt only when its enable is set.
// - Falling-edge enable makes a falling edge capture or reload; mode 0 only flags.
// - Main run bit runs the 16-bit timer, or only the high half when split.
// - Three-bit clock select picks prescaled, pin, system, event or overflow sources.
// - Two mode bits select reload, edge reload, capture, capture with auto-zero.
// - Split enable runs the counter as two independent 8-bit timers.
// - Two-bit low clock select picks prescaled, system, uart1 overflow or int1 event.
// - Rising-edge enable makes a rising edge capture or reload and set external flag.
// - Auto-clear drops low run bit on high overflow (modes 0/1) or capture (2/3).
// - Clock-out enable gates the clock onto the clock-out pin; else pin stays low.
// - Ignore bit stops the main overflow flag from requesting an interrupt.
// - Capture source select picks pin, int0, port pin, keypad or slow oscillator.
// - Writing one to a run trigger sets the matching run bit (low run bit only when split); zero does nothing.
// - Reload trigger forces reload unless capturing; separate low reload when split.
// - Writing one to a stop trigger clears the matching run bit (low run bit only when split); zero does nothing.

package sct_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MODE_EXT   = 8'h93;
  localparam logic [7:0] IDX_RUN_TRIG   = 8'h95;
  localparam logic [7:0] IDX_RELOAD_TRIG = 8'h96;
  localparam logic [7:0] IDX_STOP_TRIG  = 8'h97;
  localparam logic [7:0] IDX_CONTROL    = 8'hc8;
  localparam logic [7:0] IDX_MODE       = 8'hc9;
  localparam logic [7:0] IDX_RCAP_LO    = 8'hca;
  localparam logic [7:0] IDX_RCAP_HI    = 8'hcb;
  localparam logic [7:0] IDX_CNT_LO     = 8'hcc;
  localparam logic [7:0] IDX_CNT_HI     = 8'hcd;
  localparam logic [7:0] IDX_AUX        = 8'hce;

  // ----------------------------------------------------------------
  // Reset value and extended-mode write mask
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] MODE_EXT_RMASK = 8'hdf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_MAIN_OVF   = 7;
  localparam int CTL_EXT_FLAG   = 6;
  localparam int CTL_LOW_OVF    = 5;
  localparam int CTL_LOW_IE     = 4;
  localparam int CTL_FALL_EN    = 3;
  localparam int CTL_MAIN_RUN   = 2;
  localparam int CTL_CLKSEL0    = 1;
  localparam int CTL_MODE_A     = 0;
  localparam int MOD_SPLIT      = 7;
  localparam int MOD_LOCLKSEL0  = 6;
  localparam int MOD_RISE_EN    = 5;
  localparam int MOD_CLKSEL1    = 4;
  localparam int MOD_LOW_RUN    = 3;
  localparam int MOD_AUTO_CLR   = 2;
  localparam int MOD_CLKOUT_EN  = 1;
  localparam int MOD_MODE_B     = 0;
  localparam int EXT_LOCLKSEL1  = 7;
  localparam int EXT_OVF_IGNORE = 6;
  localparam int EXT_CLKSEL2    = 4;
  localparam int EXT_MODE_C     = 3;
  localparam int TRG_LOW        = 6;
  localparam int TRG_MAIN       = 3;
  localparam int AUX_IRQ_EN     = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned  PRESC_DIV  = 12;
  localparam logic [3:0]   PRESC_LAST = 4'(PRESC_DIV - 1);

endpackage : sct_pkg

// ==== sct_timer.sv ====
// Split-capable timer control: registers, counters, flags, clock-out.
// Assumes a classic Wishbone master and event inputs synchronous to clk_i.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps

module sct_timer
  import sct_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Clock sources
  input  wire logic        timer_pin_i,
  input  wire logic        int1_event_i,
  input  wire logic        uart1_timer_overflow_i,
  input  wire logic        timer0_overflow_i,
  input  wire logic        timer1_overflow_i,
  // Capture sources
  input  wire logic        external_input_pin_i,
  input  wire logic        int0_event_i,
  input  wire logic        fixed_port_pin_i,
  input  wire logic        keypad_event_i,
  input  wire logic        internal_slow_rc_osc_i,
  // System state
  input  wire logic        power_down_i,
  // Outputs
  output logic             clock_out_pin_o,
  output logic             overflow_event_o,
  output logic             timer_irq_o
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] ext;
    logic [7:0] aux;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] rcap_lo;
    logic [7:0] rcap_hi;
    logic [3:0] presc;
    logic       pin_prev;
    logic       cap_prev;
    logic       clk_out;
    logic       ack;
    logic [7:0] rdata;
  } sct_state_t;

  sct_state_t q_ff;
  sct_state_t nxt_q;

  logic       req;
  logic       wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic       split;
  logic       capture;
  logic [1:0] mode_sel;
  logic       tick12;
  logic       lo_tick;
  logic       main_tick;
  logic       lo_inc;
  logic       lo_ovf;
  logic       hi_inc;
  logic       hi_ovf;
  logic       ovf16;
  logic       main_ovf;
  logic       cap_lvl;
  logic       ext_evt;
  logic       pd_level;
  logic       clkout_act;
  logic [15:0] cnt16;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_q    = q_ff;
    req      = cyc_i & stb_i & ~q_ff.ack;
    wr       = req & we_i & sel_i[0];
    idx      = adr_i[9:2];
    wdat     = dat_i[7:0];
    split    = q_ff.mode[MOD_SPLIT];
    mode_sel = {q_ff.ctrl[CTL_MODE_A], q_ff.mode[MOD_MODE_B]};
    capture  = mode_sel[1];
    clkout_act = split & q_ff.mode[MOD_CLKOUT_EN];

    // Prescaler for the system clock divided by twelve
    tick12      = (q_ff.presc == PRESC_LAST);
    nxt_q.presc = tick12 ? 4'h0 : q_ff.presc + 4'h1;
    nxt_q.pin_prev = timer_pin_i;

    // Low half clock
    unique case ({q_ff.ext[EXT_LOCLKSEL1], q_ff.mode[MOD_LOCLKSEL0]})
      2'b00:   lo_tick = tick12;
      2'b01:   lo_tick = 1'b1;
      2'b10:   lo_tick = uart1_timer_overflow_i;
      default: lo_tick = int1_event_i;
    endcase
    lo_inc = split & q_ff.mode[MOD_LOW_RUN] & lo_tick;
    lo_ovf = lo_inc & (q_ff.cnt_lo == 8'hff);

    // Main clock; external pin counts on falling edges
    unique case ({q_ff.ext[EXT_CLKSEL2], q_ff.mode[MOD_CLKSEL1], q_ff.ctrl[CTL_CLKSEL0]})
      3'b000:  main_tick = tick12;
      3'b001:  main_tick = q_ff.pin_prev & ~timer_pin_i;
      3'b010:  main_tick = 1'b1;
      3'b011:  main_tick = split ? lo_ovf : int1_event_i;
      3'b100:  main_tick = uart1_timer_overflow_i;
      3'b101:  main_tick = timer0_overflow_i;
      3'b110:  main_tick = 1'b0;
      default: main_tick = timer1_overflow_i;
    endcase
    hi_inc   = q_ff.ctrl[CTL_MAIN_RUN] & main_tick;
    cnt16    = {q_ff.cnt_hi, q_ff.cnt_lo};
    ovf16    = ~split & hi_inc & (cnt16 == 16'hffff);
    hi_ovf   = split & hi_inc & (q_ff.cnt_hi == 8'hff);
    main_ovf = ovf16 | hi_ovf;

    // Capture source; reserved codes hold the last level so no edge appears
    unique case (q_ff.ext[2:0])
      3'b000:  cap_lvl = external_input_pin_i;
      3'b001:  cap_lvl = int0_event_i;
      3'b010:  cap_lvl = fixed_port_pin_i;
      3'b100:  cap_lvl = keypad_event_i;
      3'b111:  cap_lvl = internal_slow_rc_osc_i;
      default: cap_lvl = q_ff.cap_prev;
    endcase
    nxt_q.cap_prev = cap_lvl;
    ext_evt = (q_ff.cap_prev & ~cap_lvl & q_ff.ctrl[CTL_FALL_EN])
            | (~q_ff.cap_prev & cap_lvl & q_ff.mode[MOD_RISE_EN]);
    pd_level = power_down_i & q_ff.aux[AUX_IRQ_EN]
             & ((q_ff.ctrl[CTL_FALL_EN] & ~cap_lvl) | (q_ff.mode[MOD_RISE_EN] & cap_lvl));

    // Counters
    if (split)
    begin
      if (lo_inc)
        nxt_q.cnt_lo = lo_ovf ? q_ff.rcap_lo : q_ff.cnt_lo + 8'h01;
      if (hi_inc)
        nxt_q.cnt_hi = hi_ovf ? (capture ? 8'h00 : q_ff.rcap_hi) : q_ff.cnt_hi + 8'h01;
      if (ext_evt)
      begin
        unique case (mode_sel)
          2'b00:   ;
          2'b01:   nxt_q.cnt_hi = q_ff.rcap_hi;
          2'b10:   nxt_q.rcap_hi = q_ff.cnt_hi;
          default:
          begin
            nxt_q.rcap_hi = q_ff.cnt_hi;
            nxt_q.cnt_hi  = 8'h00;
          end
        endcase
      end
    end
    else
    begin
      if (hi_inc)
        {nxt_q.cnt_hi, nxt_q.cnt_lo} = ovf16 ? (capture ? 16'h0000 : {q_ff.rcap_hi, q_ff.rcap_lo})
                                             : cnt16 + 16'h0001;
      if (ext_evt)
      begin
        unique case (mode_sel)
          2'b00:   ;
          2'b01:   {nxt_q.cnt_hi, nxt_q.cnt_lo} = {q_ff.rcap_hi, q_ff.rcap_lo};
          2'b10:   {nxt_q.rcap_hi, nxt_q.rcap_lo} = cnt16;
          default:
          begin
            {nxt_q.rcap_hi, nxt_q.rcap_lo} = cnt16;
            {nxt_q.cnt_hi, nxt_q.cnt_lo}   = 16'h0000;
          end
        endcase
      end
    end

    // Clock-out toggle, parked low while disabled
    if (!q_ff.mode[MOD_CLKOUT_EN])
      nxt_q.clk_out = 1'b0;
    else if (split ? lo_ovf : (ovf16 & ~q_ff.ctrl[CTL_MODE_A]))
      nxt_q.clk_out = ~q_ff.clk_out;

    // Software writes to plain registers
    if (wr)
    begin
      unique case (idx)
        IDX_CONTROL:  nxt_q.ctrl    = wdat;
        IDX_MODE:     nxt_q.mode    = wdat;
        IDX_MODE_EXT: nxt_q.ext     = wdat & MODE_EXT_RMASK;
        IDX_AUX:      nxt_q.aux     = {7'h00, wdat[AUX_IRQ_EN]};
        IDX_RCAP_LO:  nxt_q.rcap_lo = wdat;
        IDX_RCAP_HI:  nxt_q.rcap_hi = wdat;
        IDX_CNT_LO:   nxt_q.cnt_lo  = wdat;
        IDX_CNT_HI:   nxt_q.cnt_hi  = wdat;
        default:      ;
      endcase
    end

    // Trigger registers act once and store nothing
    if (wr && idx == IDX_RELOAD_TRIG)
    begin
      if (wdat[TRG_MAIN] && !capture)
      begin
        nxt_q.cnt_hi = q_ff.rcap_hi;
        if (!split)
          nxt_q.cnt_lo = q_ff.rcap_lo;
      end
      if (wdat[TRG_LOW] && split)
        nxt_q.cnt_lo = q_ff.rcap_lo;
    end
    if (wr && idx == IDX_RUN_TRIG)
    begin
      if (wdat[TRG_MAIN])
        nxt_q.ctrl[CTL_MAIN_RUN] = 1'b1;
      if (wdat[TRG_LOW] && split)
        nxt_q.mode[MOD_LOW_RUN] = 1'b1;
    end
    if (wr && idx == IDX_STOP_TRIG)
    begin
      if (wdat[TRG_MAIN])
        nxt_q.ctrl[CTL_MAIN_RUN] = 1'b0;
      if (wdat[TRG_LOW] && split)
        nxt_q.mode[MOD_LOW_RUN] = 1'b0;
    end
    if (split && q_ff.mode[MOD_AUTO_CLR] && (capture ? ext_evt : hi_ovf))
      nxt_q.mode[MOD_LOW_RUN] = 1'b0;

    // Hardware flag sets come last so a set beats a clear in the same cycle
    if (main_ovf)
      nxt_q.ctrl[CTL_MAIN_OVF] = 1'b1;
    if (ext_evt || pd_level)
      nxt_q.ctrl[CTL_EXT_FLAG] = 1'b1;
    if (lo_ovf && !clkout_act)
      nxt_q.ctrl[CTL_LOW_OVF] = 1'b1;

    // Bus answer one cycle after the request; unmapped reads give zero
    nxt_q.ack = req;
    unique case (idx)
      IDX_CONTROL:  nxt_q.rdata = q_ff.ctrl;
      IDX_MODE:     nxt_q.rdata = q_ff.mode;
      IDX_MODE_EXT: nxt_q.rdata = q_ff.ext;
      IDX_AUX:      nxt_q.rdata = q_ff.aux;
      IDX_RCAP_LO:  nxt_q.rdata = q_ff.rcap_lo;
      IDX_RCAP_HI:  nxt_q.rdata = q_ff.rcap_hi;
      IDX_CNT_LO:   nxt_q.rdata = q_ff.cnt_lo;
      IDX_CNT_HI:   nxt_q.rdata = q_ff.cnt_hi;
      default:      nxt_q.rdata = RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o            = {24'h000000, q_ff.rdata};
  assign ack_o            = q_ff.ack;
  assign clock_out_pin_o  = q_ff.clk_out & q_ff.mode[MOD_CLKOUT_EN];
  // Split mode hands the overflow event over to the low half
  assign overflow_event_o = split ? lo_ovf : ovf16;
  assign timer_irq_o      = q_ff.aux[AUX_IRQ_EN]
                          & ((q_ff.ctrl[CTL_MAIN_OVF] & ~q_ff.ext[EXT_OVF_IGNORE])
                          |  q_ff.ctrl[CTL_EXT_FLAG]
                          |  (q_ff.ctrl[CTL_LOW_OVF] & q_ff.ctrl[CTL_LOW_IE]));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic wr_ctrl;
  logic wr_cnt_lo;
  assign wr_ctrl   = wr && idx == IDX_CONTROL;
  assign wr_cnt_lo = wr && (idx == IDX_CNT_LO || idx == IDX_RELOAD_TRIG);

  sequence s_low_roll;
    lo_ovf && !wr_cnt_lo;
  endsequence

  a_low_reload: assert property (s_low_roll |=> q_ff.cnt_lo == $past(q_ff.rcap_lo))
    else $error("low half did not reload");
  a_clkout_toggle: assert property (lo_ovf && clkout_act && !(wr && idx == IDX_MODE)
                                    |=> q_ff.clk_out != $past(q_ff.clk_out))
    else $error("clock-out did not toggle");
  a_low_flag_mute: assert property (lo_ovf && clkout_act && !q_ff.ctrl[CTL_LOW_OVF]
                                    && !wr_ctrl |=> !q_ff.ctrl[CTL_LOW_OVF])
    else $error("low flag set during clock-out");
  a_main_flag_set: assert property (main_ovf |=> q_ff.ctrl[CTL_MAIN_OVF])
    else $error("overflow flag missed");
  a_ext_flag_set: assert property (ext_evt |=> q_ff.ctrl[CTL_EXT_FLAG])
    else $error("external flag missed");
  a_irq_ignore: assert property (q_ff.aux[AUX_IRQ_EN] && q_ff.ext[EXT_OVF_IGNORE]
                                 && !q_ff.ctrl[CTL_EXT_FLAG] && !q_ff.ctrl[CTL_LOW_OVF]
                                 |-> !timer_irq_o)
    else $error("ignored overflow raised interrupt");
  a_low_irq_gate: assert property (q_ff.aux[AUX_IRQ_EN] && q_ff.ctrl[CTL_LOW_OVF]
                                   |-> timer_irq_o == (q_ff.ctrl[CTL_LOW_IE]
                                   || q_ff.ctrl[CTL_EXT_FLAG]
                                   || (q_ff.ctrl[CTL_MAIN_OVF] && !q_ff.ext[EXT_OVF_IGNORE])))
    else $error("low interrupt gating wrong");
  a_run_trigger: assert property (wr && idx == IDX_RUN_TRIG && wdat[TRG_MAIN]
                                  |=> q_ff.ctrl[CTL_MAIN_RUN])
    else $error("run trigger ignored");
  a_stop_trigger: assert property (wr && idx == IDX_STOP_TRIG && wdat[TRG_MAIN]
                                   |=> !q_ff.ctrl[CTL_MAIN_RUN])
    else $error("stop trigger ignored");
  a_auto_clear: assert property (hi_ovf && !capture && q_ff.mode[MOD_AUTO_CLR]
                                 && !wr |=> !q_ff.mode[MOD_LOW_RUN])
    else $error("low run not auto-cleared");
  a_clkout_off: assert property (!q_ff.mode[MOD_CLKOUT_EN] |=> !q_ff.clk_out)
    else $error("clock-out driven while disabled");
  a_bus_answer: assert property (req |=> ack_o ##1 !ack_o)
    else $error("bus answer malformed");

endmodule : sct_timer

// ==== tb.sv ====
// Self-checking bench for the split-capable timer control block.
// Assumes the design package and a single 100 MHz clock domain.
`timescale 1ns/100ps

module tb;
  import sct_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc_i   = 1'b0;
  logic        stb_i   = 1'b0;
  logic        we_i    = 1'b0;
  logic [9:0]  adr_i   = 10'h000;
  logic [3:0]  sel_i   = 4'h0;
  logic [31:0] dat_i   = 32'h0;
  logic [4:0]  evt     = 5'h00;
  logic [4:0]  cap     = 5'h1f;
  logic        pd      = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        clock_out_pin_o;
  logic        overflow_event_o;
  logic        timer_irq_o;
  int          n_errors        = 0;
  int          samples_checked = 0;
  int          n_ovf           = 0;
  int          n_tog           = 0;
  logic        win             = 1'b0;
  logic        last_co         = 1'b0;
  logic [7:0]  r;
  logic [7:0]  r2;
  logic [15:0] v;
  int          src_code [5]    = '{0, 1, 2, 4, 7};

  always #5 clk_i = ~clk_i;

  sct_timer u_sct_timer (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .timer_pin_i(evt[0]), .int1_event_i(evt[1]), .uart1_timer_overflow_i(evt[2]),
    .timer0_overflow_i(evt[3]), .timer1_overflow_i(evt[4]),
    .external_input_pin_i(cap[0]), .int0_event_i(cap[1]), .fixed_port_pin_i(cap[2]),
    .keypad_event_i(cap[3]), .internal_slow_rc_osc_i(cap[4]), .power_down_i(pd),
    .clock_out_pin_o(clock_out_pin_o), .overflow_event_o(overflow_event_o),
    .timer_irq_o(timer_irq_o)
  );

  // Unselected clock sources chatter so that wrong selection shows up
  always @(posedge clk_i) evt <= 5'($urandom);

  always @(negedge clk_i)
  begin
    if (win && overflow_event_o === 1'b1) n_ovf++;
    if (win && clock_out_pin_o !== last_co) n_tog++;
    last_co = clock_out_pin_o;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                    output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hf;
    dat_i <= {24'h0, wd};
    n = 0;
    // Ack and read data are taken at the rising edge, before it updates them
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1)
    begin
      n_errors++;
      wrap_up();
    end
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb(1'b1, idx, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    wb(1'b0, idx, 8'h00, d);
  endtask : rd

  // Bounded poll until any masked bit of a register reads one
  task automatic poll(input logic [7:0] idx, input logic [7:0] m);
    logic [7:0] x;
    int         n;
    n = 0;
    x = 8'h00;
    while ((x & m) == 8'h00 && n < 60)
    begin
      rd(idx, x);
      n++;
    end
    if (n >= 60)
    begin
      n_errors++;
      wrap_up();
    end
  endtask : poll

  function automatic logic [7:0] ext_exp(input logic [7:0] w);
    return w & MODE_EXT_RMASK;
  endfunction : ext_exp

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(60314));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (src_code[i])
    begin
      rd(IDX_CONTROL + 8'(i % 2), r);
      chk("reset", RST_BYTE, r);
    end
    rd(IDX_MODE_EXT, r);
    chk("mode_ext reset", RST_BYTE, r);
    rd(8'h10, r);
    chk("unmapped", 8'h00, r);
    // Field storage with every run and flag source quiet
    repeat (4)
    begin
      v = 16'($urandom);
      wr(IDX_MODE_EXT, v[7:0] & 8'h38);
      rd(IDX_MODE_EXT, r);
      chk("mode_ext", ext_exp(v[7:0] & 8'h38), r);
      wr(IDX_MODE, v[15:8] & 8'h75);
      rd(IDX_MODE, r);
      chk("mode", v[15:8] & 8'h75, r);
    end
    wr(IDX_MODE_EXT, 8'h00);
    wr(IDX_MODE, 8'h10);
    // Full timer: run trigger, overflow flag, ignore bit, stop trigger
    wr(IDX_CNT_LO, 8'hfe);
    wr(IDX_CNT_HI, 8'hff);
    wr(IDX_RCAP_LO, 8'h34);
    wr(IDX_RCAP_HI, 8'h12);
    wr(IDX_RUN_TRIG, 8'h08);
    rd(IDX_RUN_TRIG, r);
    chk("run trig self clear", 8'h00, r);
    poll(IDX_CONTROL, 8'h80);
    wr(IDX_STOP_TRIG, 8'h00);
    rd(IDX_CONTROL, r);
    chk("control after stop 0", 8'h84, r);
    wr(IDX_STOP_TRIG, 8'h08);
    rd(IDX_CONTROL, r);
    chk("control stopped", 8'h80, r);
    rd(IDX_CNT_HI, r);
    chk("reload high", 8'h12, r);
    wr(IDX_AUX, 8'h01);
    @(negedge clk_i);
    chk("irq main", 8'h01, {7'h0, timer_irq_o});
    wr(IDX_MODE_EXT, 8'h40);
    @(negedge clk_i);
    chk("irq ignored", 8'h00, {7'h0, timer_irq_o});
    wr(IDX_MODE_EXT, 8'h00);
    wr(IDX_CONTROL, 8'h00);
    // Split low half: reload, low flag, enable, clock-out
    wr(IDX_MODE, 8'hc0);
    wr(IDX_CONTROL, 8'h10);
    wr(IDX_RCAP_LO, 8'hfc);
    wr(IDX_CNT_LO, 8'hfc);
    wr(IDX_RUN_TRIG, 8'h40);
    rd(IDX_MODE, r);
    chk("low run", 8'hc8, r);
    poll(IDX_CONTROL, 8'h20);
    @(negedge clk_i);
    chk("irq low", 8'h01, {7'h0, timer_irq_o});
    chk("clkout off", 8'h00, {7'h0, clock_out_pin_o});
    rd(IDX_CNT_LO, r);
    chk("low reload", 8'h3f, {2'b00, r[7:2]});
    rd(IDX_CONTROL, r);
    chk("main untouched", 8'h00, r & 8'h84);
    wr(IDX_CONTROL, 8'h00);
    @(negedge clk_i);
    chk("irq low masked", 8'h00, {7'h0, timer_irq_o});
    wr(IDX_MODE, 8'hc2);
    wr(IDX_RUN_TRIG, 8'h40);
    wr(IDX_CONTROL, 8'h10);
    win = 1'b1;
    repeat (200) @(posedge clk_i);
    win = 1'b0;
    chk("toggles per overflow", 8'h01, 8'(n_ovf > 10 && (n_tog - n_ovf) inside {-1, 0, 1}));
    rd(IDX_CONTROL, r);
    chk("no low flag clkout", 8'h00, r & 8'h20);
    wr(IDX_STOP_TRIG, 8'h40);
    rd(IDX_MODE, r);
    chk("low stop", 8'hc2, r);
    wr(IDX_MODE, 8'h00);
    wr(IDX_CONTROL, 8'h00);
    // External flag on each capture source, falling then rising
    foreach (src_code[i])
    begin
      wr(IDX_MODE_EXT, 8'(src_code[i]));
      wr(IDX_CONTROL, 8'h08);
      @(posedge clk_i) cap[i] <= 1'b0;
      rd(IDX_CONTROL, r);
      chk("ext fall", 8'h48, r);
      wr(IDX_CONTROL, 8'h00);
      wr(IDX_MODE, 8'h20);
      @(posedge clk_i) cap[i] <= 1'b1;
      rd(IDX_CONTROL, r);
      chk("ext rise", 8'h40, r);
      wr(IDX_MODE, 8'h00);
      wr(IDX_CONTROL, 8'h00);
    end
    wr(IDX_MODE_EXT, 8'h00);
    // Capture, capture with auto-zero, mode 0 report only, forced reload
    for (int m = 0; m < 3; m++)
    begin
      v = 16'($urandom);
      wr(IDX_CNT_LO, v[7:0]);
      wr(IDX_CNT_HI, v[15:8]);
      wr(IDX_RCAP_LO, 8'h5a);
      wr(IDX_RCAP_HI, 8'ha5);
      wr(IDX_MODE, m == 1 ? 8'h01 : 8'h00);
      wr(IDX_CONTROL, m == 2 ? 8'h08 : 8'h09);
      @(posedge clk_i) cap[0] <= 1'b0;
      rd(IDX_RCAP_HI, r);
      chk("rcap hi", m == 2 ? 8'ha5 : v[15:8], r);
      rd(IDX_CNT_LO, r2);
      chk("cnt lo", m == 1 ? 8'h00 : v[7:0], r2);
      rd(IDX_CONTROL, r);
      chk("ext flag", 8'h40, r & 8'h40);
      wr(IDX_RELOAD_TRIG, 8'h08);
      rd(IDX_CNT_LO, r);
      chk("forced reload", m == 2 ? 8'h5a : r2, r);
      @(posedge clk_i) cap[0] <= 1'b1;
    end
    // Power-down holds the external flag while the input stays active
    wr(IDX_CONTROL, 8'h08);
    pd <= 1'b1;
    @(posedge clk_i) cap[0] <= 1'b0;
    wr(IDX_CONTROL, 8'h08);
    rd(IDX_CONTROL, r);
    chk("pd level", 8'h48, r);
    pd <= 1'b0;
    wr(IDX_CONTROL, 8'h08);
    rd(IDX_CONTROL, r);
    chk("pd released", 8'h08, r);
    wrap_up();
  end
endmodule : tb
